// >>> hw/cmr_pkg.sv
package cmr_pkg;

  localparam int NUM_CMP = 3;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_CMP1 = 12'h000;
  localparam logic [11:0] OFS_CMP2 = 12'h004;
  localparam logic [11:0] OFS_CMP3 = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00c;
  localparam logic [11:0] OFS_VREF = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h018;
  localparam logic [11:0] OFS_IRQ_EN = 12'h01c;

  // comparator_control fields
  localparam int CTL_EN = 15;
  localparam int CTL_OE = 14;
  localparam int CTL_POL = 13;
  localparam int CTL_EVT = 9;
  localparam int CTL_OUT = 8;
  localparam int CTL_EVPOL = 6;
  localparam int CTL_NONINV_REFERENCE_SELECT = 4;
  localparam int CTL_CCH = 0;
  localparam logic [15:0] CTL_CFG_MASK = 16'he0d3;

  // comparator_module_status fields
  localparam int STAT_IDLE = 15;
  localparam int STAT_EVT = 8;
  localparam int STAT_OUT = 0;

  // voltage_reference_control fields
  localparam int VREF_LVL = 0;
  localparam logic [15:0] VREF_MASK = 16'h07ff;

  // Reset values
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] VREF_RST = 16'h0000;
  localparam logic STAT_IDLE_RST = 1'b0;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {EV_OFF, EV_RISE, EV_FALL, EV_ANY} cmr_evpol_e;

  // Same bit order as voltage_reference_control[10:0]
  typedef struct packed {
    logic refPinSel;
    logic [1:0] bandgapSel;
    logic powerEn;
    logic pinOe;
    logic supplySel;
    logic [4:0] level;
  } cmr_vref_s;

  typedef struct packed {
    logic noninvRefSel;
    logic [1:0] invChanSel;
  } cmr_route_s;

endpackage

// >>> hw/cmr_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Reference-select bit routes noninverting input to internal reference, else pin A.
// - Channel field routes inverting input: pin B, C, D, or band-gap reference.
// - Idle-stop bit halts all comparators while the device is idle.
// - Status bits 10..8 mirror the event flags of comparators 3..1.
// - Status bits 2..0 mirror the outputs of comparators 3..1.
// - Programmable reference offers 32 levels via a 5-bit field.
// - Supply-select bit picks external reference pins or analog supply rails.
// - Reference-pin select supplies positive reference pin or ladder output.
// - Band-gap field: band gap, band gap halved, reserved, positive reference pin.
// - Power-enable bit powers the reference ladder on or down.
// - Pin output enable drives the reference level onto its pin.
// - Level field sets output to level/32 of the selected span.
// - Event flag sets on polarity event; blocks triggers until software clears.
// - Output bit follows comparison, inverted when polarity bit is set.
module cmr_regs
  import cmr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idleMode,
  input wire logic [NUM_CMP-1:0] cmpRaw,
  output logic [NUM_CMP-1:0] cmpRun,
  output logic [NUM_CMP-1:0] cmpPinOe,
  output logic [NUM_CMP-1:0] cmpPinOut,
  output logic [NUM_CMP-1:0] cmpTrigger,
  output cmr_route_s [NUM_CMP-1:0] cmpRoute,
  output cmr_vref_s vrefCfg,
  output logic irq
);

  logic [15:0] cmpCtl_r [NUM_CMP];
  logic [15:0] vrefReg_r;
  logic idleStop_r;
  logic [NUM_CMP-1:0] evt_r;
  logic [NUM_CMP-1:0] outBit_r;
  logic [NUM_CMP-1:0] prevRaw_r;
  logic [NUM_CMP-1:0] sync1_r;
  logic [NUM_CMP-1:0] sync2_r;
  logic [NUM_CMP-1:0] run_r;
  logic [NUM_CMP-1:0] trig_r;
  logic [NUM_CMP-1:0] irqStat_r;
  logic [NUM_CMP-1:0] irqEn_r;
  logic [NUM_CMP-1:0] hit;
  logic awHave_r;
  logic wHave_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wrDo;
  logic wrMapped;
  logic [2:0] wrIdx;
  logic [15:0] statWord;

  function automatic logic [15:0] mergeWord(logic [15:0] old, logic [31:0] data, logic [3:0] strb, logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res & mask;
  endfunction

  function automatic logic [15:0] ctlWord(logic [15:0] cfg, logic ev, logic ob);
    logic [15:0] res;
    res = cfg & CTL_CFG_MASK;
    res[CTL_EVT] = ev;
    res[CTL_OUT] = ob;
    return res;
  endfunction

  // Write channel: address and data taken in either order
  assign s_axi_awready = !awHave_r && !bvalid_r;
  assign s_axi_wready = !wHave_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  assign wrDo = awHave_r && wHave_r && !bvalid_r;
  assign wrIdx = awAddr_r[4:2];
  assign wrMapped = (awAddr_r[ADDR_W-1:5] == '0) && (awAddr_r[1:0] == 2'h0);

  always_ff @(posedge mclk) begin
    if (reset) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrDo) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        cmpCtl_r[i] <= CTL_RST;
      end
      vrefReg_r <= VREF_RST;
      idleStop_r <= STAT_IDLE_RST;
      irqEn_r <= IRQ_EN_RST;
    end else if (wrDo && wrMapped) begin
      unique case (awAddr_r[4:0])
        OFS_CMP1[4:0]: cmpCtl_r[0] <= mergeWord(cmpCtl_r[0], wData_r, wStrb_r, CTL_CFG_MASK);
        OFS_CMP2[4:0]: cmpCtl_r[1] <= mergeWord(cmpCtl_r[1], wData_r, wStrb_r, CTL_CFG_MASK);
        OFS_CMP3[4:0]: cmpCtl_r[2] <= mergeWord(cmpCtl_r[2], wData_r, wStrb_r, CTL_CFG_MASK);
        OFS_VREF[4:0]: vrefReg_r <= mergeWord(vrefReg_r, wData_r, wStrb_r, VREF_MASK);
        OFS_STAT[4:0]: begin
          if (wStrb_r[1]) begin
            idleStop_r <= wData_r[STAT_IDLE];
          end
        end
        OFS_IRQ_EN[4:0]: begin
          if (wStrb_r[0]) begin
            irqEn_r <= wData_r[NUM_CMP-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Analog routing straight from configuration
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      cmpRoute[i].noninvRefSel = cmpCtl_r[i][CTL_NONINV_REFERENCE_SELECT];
      cmpRoute[i].invChanSel = cmpCtl_r[i][CTL_CCH+:2];
    end
  end

  assign vrefCfg = cmr_vref_s'(vrefReg_r[10:0]);

  // Comparison result crosses in from the analog side
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= cmpRaw;
      sync2_r <= sync1_r;
    end
  end

  // Stop in idle, registered so the analog enable is glitch free
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        run_r[i] <= cmpCtl_r[i][CTL_EN] && !(idleMode && idleStop_r);
      end
    end
  end

  // Polarity event detection on the raw comparison
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      unique case (cmr_evpol_e'(cmpCtl_r[i][CTL_EVPOL+:2]))
        EV_OFF: hit[i] = 1'b0;
        EV_RISE: hit[i] = sync2_r[i] && !prevRaw_r[i];
        EV_FALL: hit[i] = !sync2_r[i] && prevRaw_r[i];
        EV_ANY: hit[i] = sync2_r[i] ^ prevRaw_r[i];
      endcase
      // A set flag blocks further events
      hit[i] = hit[i] && run_r[i] && !evt_r[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prevRaw_r <= '0;
      outBit_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        // Stopped comparator holds its last result
        if (run_r[i]) begin
          prevRaw_r[i] <= sync2_r[i];
          outBit_r[i] <= sync2_r[i] ^ cmpCtl_r[i][CTL_POL];
        end
      end
    end
  end

  // Event flag; a hardware set beats a software clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      evt_r <= '0;
      trig_r <= '0;
    end else begin
      trig_r <= hit;
      for (int i = 0; i < NUM_CMP; i++) begin
        if (hit[i]) begin
          evt_r[i] <= 1'b1;
        end else if (wrDo && wrMapped && wrIdx == 3'(i) && wStrb_r[1]) begin
          evt_r[i] <= wData_r[CTL_EVT];
        end
      end
    end
  end

  // Sticky interrupt status; set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqStat_r <= '0;
    end else if (wrDo && wrMapped && awAddr_r[4:0] == OFS_IRQ_CLR[4:0] && wStrb_r[0]) begin
      irqStat_r <= hit | (irqStat_r & ~wData_r[NUM_CMP-1:0]);
    end else begin
      irqStat_r <= hit | irqStat_r;
    end
  end

  assign irq = |(irqStat_r & irqEn_r);
  assign cmpRun = run_r;
  assign cmpPinOe = {cmpCtl_r[2][CTL_OE], cmpCtl_r[1][CTL_OE], cmpCtl_r[0][CTL_OE]};
  assign cmpPinOut = outBit_r;
  assign cmpTrigger = trig_r;

  always_comb begin
    statWord = 16'h0000;
    statWord[STAT_IDLE] = idleStop_r;
    statWord[STAT_EVT+:NUM_CMP] = evt_r;
    statWord[STAT_OUT+:NUM_CMP] = outBit_r;
  end

  // Read channel, one cycle to answer
  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      if (s_axi_araddr[ADDR_W-1:5] != '0 || s_axi_araddr[1:0] != 2'h0) begin
        rresp_r <= RESP_SLVERR;
      end else begin
        // Unimplemented bits and write-only clear read zero
        unique case (s_axi_araddr[4:0])
          OFS_CMP1[4:0]: rdata_r[15:0] <= ctlWord(cmpCtl_r[0], evt_r[0], outBit_r[0]);
          OFS_CMP2[4:0]: rdata_r[15:0] <= ctlWord(cmpCtl_r[1], evt_r[1], outBit_r[1]);
          OFS_CMP3[4:0]: rdata_r[15:0] <= ctlWord(cmpCtl_r[2], evt_r[2], outBit_r[2]);
          OFS_STAT[4:0]: rdata_r[15:0] <= statWord;
          OFS_VREF[4:0]: rdata_r[15:0] <= vrefReg_r & VREF_MASK;
          OFS_IRQ_STAT[4:0]: rdata_r[NUM_CMP-1:0] <= irqStat_r;
          OFS_IRQ_EN[4:0]: rdata_r[NUM_CMP-1:0] <= irqEn_r;
          default: ;
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  noninv_reference_select_route_a: assert property (wrDo && awAddr_r == OFS_CMP1 && wStrb_r[0]
    |=> cmpRoute[0].noninvRefSel == $past(wData_r[CTL_NONINV_REFERENCE_SELECT]))
    else $error("noninverting route not updated");
  cch_route_a: assert property (wrDo && awAddr_r == OFS_CMP2 && wStrb_r[0]
    |=> cmpRoute[1].invChanSel == $past(wData_r[1:0]))
    else $error("inverting route not updated");
  idle_stop_a: assert property (idleMode && idleStop_r |=> run_r == '0)
    else $error("comparator runs in idle");
  evt_mirror_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STAT
    |=> s_axi_rdata[10:8] == $past(evt_r))
    else $error("event mirror wrong");
  out_mirror_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STAT
    |=> s_axi_rdata[2:0] == $past(outBit_r))
    else $error("output mirror wrong");
  level_set_a: assert property (wrDo && awAddr_r == OFS_VREF && wStrb_r[0]
    |=> vrefCfg.level == $past(wData_r[4:0]) && vrefCfg.supplySel == $past(wData_r[5]))
    else $error("reference level not updated");
  evt_block_a: assert property (evt_r[0] && !wrDo |=> evt_r[0] ##1 !cmpTrigger[0])
    else $error("event flag lost or trigger leaked");
  out_invert_a: assert property (run_r[0]
    |=> outBit_r[0] == ($past(sync2_r[0]) ^ $past(cmpCtl_r[0][CTL_POL])))
    else $error("output polarity wrong");
  ro_ignore_a: assert property (wrDo && awAddr_r == OFS_VREF |=> vrefReg_r[15:11] == 5'h0)
    else $error("unimplemented bits stored");
  irq_raise_a: assert property (hit[0] && irqEn_r[0] && !wrDo |=> irq)
    else $error("interrupt not raised");
endmodule

// >>> test/cmr_regs_tb.sv
`timescale 1ns/1ps
module cmr_regs_tb
  import cmr_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic idleMode = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic [NUM_CMP-1:0] cmpRaw = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [NUM_CMP-1:0] cmpRun, cmpPinOe, cmpPinOut, cmpTrigger;
  cmr_route_s [NUM_CMP-1:0] cmpRoute;
  cmr_vref_s vrefCfg;
  int errorCnt = 0;
  int totalChecks = 0;
  int trigCnt [NUM_CMP] = '{default: 0};

  cmr_regs dut_u (
    .mclk(mclk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .idleMode(idleMode), .cmpRaw(cmpRaw), .cmpRun(cmpRun), .cmpPinOe(cmpPinOe),
    .cmpPinOut(cmpPinOut), .cmpTrigger(cmpTrigger), .cmpRoute(cmpRoute),
    .vrefCfg(vrefCfg), .irq(irq)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // Pulses are one cycle wide, so every edge counts
  always @(posedge mclk) begin
    for (int k = 0; k < NUM_CMP; k++) begin
      if (cmpTrigger[k] === 1'b1) begin
        trigCnt[k] <= trigCnt[k] + 1;
      end
    end
  end

  task automatic closeOut();
    $display("Checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is sampled on the falling edge; inputs only move on rising edges
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aw, w, b;
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      rsp = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
  endtask

  task automatic rdReg(input logic [11:0] a);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar = arvalid && arready;
      r = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
    end while (!r);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    rdReg(a);
    chk(nm, rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    closeOut();
  end

  initial begin
    logic [11:0] ofs [7];
    int i, c;
    ofs = '{OFS_CMP1, OFS_CMP2, OFS_CMP3, OFS_STAT, OFS_VREF, OFS_IRQ_STAT, OFS_IRQ_EN};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 7; i++) rdChk(ofs[i], 32'h0, "reset value");
    chk("irq after reset", {31'h0, irq}, 32'h0);
    // Read-only result bit and unused positions must not stick
    wr(OFS_CMP1, 16'h1d3f);
    rdChk(OFS_CMP1, 32'h0013, "cmp1 ctl");
    wr(OFS_VREF, 16'hffff);
    rdChk(OFS_VREF, 32'h07ff, "vref ctl");
    chk("vref cfg all", {21'h0, vrefCfg}, 32'h07ff);
    for (i = 0; i < 3; i++) begin
      for (c = 0; c < 8; c++) begin
        wr(OFS_CMP1 + 12'(4 * i), {11'h0, c[2], 2'h0, c[1:0]});
        chk("route", {29'h0, cmpRoute[i]}, 32'(c));
      end
    end
    for (i = 0; i < 11; i++) begin
      wr(OFS_VREF, 16'h1 << i);
      chk("vref field", {21'h0, vrefCfg}, 32'h1 << i);
    end
    for (i = 0; i < 32; i++) begin
      wr(OFS_VREF, 16'h0080 | 16'(i));
      chk("vref level", {21'h0, vrefCfg}, 32'h0080 | 32'(i));
    end
    // Idle stop on comparator 1, the only comparator enabled
    wr(OFS_STAT, 16'hffff);
    rdChk(OFS_STAT, 32'h8000, "stat idle");
    wr(OFS_CMP1, 16'h8000);
    idleMode <= 1'b1;
    cyc(3);
    chk("run idle stop", {29'h0, cmpRun}, 32'h0);
    wr(OFS_STAT, 16'h0000);
    cyc(3);
    chk("run idle keep", {29'h0, cmpRun}, 32'h1);
    idleMode <= 1'b0;
    // Rising event on comparator 2 with its interrupt enabled
    wr(OFS_IRQ_EN, 16'h0002);
    wr(OFS_CMP2, 16'h8040);
    cmpRaw <= 3'b010;
    cyc(8);
    chk("pin out", {29'h0, cmpPinOut}, 32'h2);
    rdChk(OFS_STAT, 32'h0202, "stat event");
    rdChk(OFS_CMP2, 32'h8340, "cmp2 ctl");
    chk("irq set", {31'h0, irq}, 32'h1);
    chk("trigger count", 32'(trigCnt[1]), 32'h1);
    rdChk(OFS_IRQ_STAT, 32'h2, "irq stat");
    // A second edge while the flag stands must stay silent
    cmpRaw <= 3'b000;
    cyc(8);
    cmpRaw <= 3'b010;
    cyc(8);
    chk("trigger blocked", 32'(trigCnt[1]), 32'h1);
    wr(OFS_CMP2, 16'ha240);
    cyc(4);
    chk("pin out inv", {29'h0, cmpPinOut}, 32'h0);
    rdChk(OFS_STAT, 32'h0200, "stat inv");
    wr(OFS_IRQ_EN, 16'h0000);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_CLR, 16'h0002);
    rdChk(OFS_IRQ_STAT, 32'h0, "irq stat clr");
    wr(OFS_CMP2, 16'ha040);
    rdChk(OFS_STAT, 32'h0, "stat clr");
    wr(OFS_IRQ_EN, 16'h0002);
    chk("irq clear", {31'h0, irq}, 32'h0);
    cmpRaw <= 3'b000;
    cyc(8);
    cmpRaw <= 3'b010;
    cyc(8);
    chk("trigger again", 32'(trigCnt[1]), 32'h2);
    chk("irq again", {31'h0, irq}, 32'h1);
    // Any-change on comparator 3, falling-only on comparator 1
    wr(OFS_IRQ_EN, 16'h0005);
    wr(OFS_CMP3, 16'h80c0);
    wr(OFS_CMP1, 16'hc080);
    chk("pin oe", {29'h0, cmpPinOe}, 32'h1);
    cmpRaw <= 3'b111;
    cyc(8);
    chk("fall mode on rise", 32'(trigCnt[0]), 32'h0);
    chk("any mode on rise", 32'(trigCnt[2]), 32'h1);
    chk("irq cmp3", {31'h0, irq}, 32'h1);
    rdChk(OFS_STAT, 32'h0605, "stat any");
    wr(OFS_CMP3, 16'h80c0);
    cmpRaw <= 3'b010;
    cyc(8);
    chk("fall mode on fall", 32'(trigCnt[0]), 32'h1);
    chk("any mode on fall", 32'(trigCnt[2]), 32'h2);
    rdChk(OFS_STAT, 32'h0700, "stat all events");
    // Unmapped and unaligned places
    rdReg(12'h020);
    chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd, 32'h0);
    wr(12'h002, 16'hffff);
    chk("unaligned bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdChk(OFS_CMP1, 32'hc280, "cmp1 untouched");
    closeOut();
  end
endmodule
